/* File: twb_bus_monitor.sv */
`timescale 1ns/1ps
module twb_bus_monitor
    import twb_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic scl_i,
    input wire logic sda_i,
    twb_line_if.mon line
);
    logic [1:0] scl_sync_q; // [0] is read only by [1]
    logic [1:0] sda_sync_q;
    logic scl_d1_q; // previous synchronised levels
    logic sda_d1_q;
    logic [2:0] free_cnt_q; // delay from stop to free
    logic stop_seen_q;
    logic busy_q;

    // two-stage synchronisers for the pins
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end
        else if (clk_en_i)
        begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_d1_q <= scl_sync_q[1];
            sda_d1_q <= sda_sync_q[1];
        end
    end

    assign line.scl = scl_sync_q[1];
    assign line.sda = sda_sync_q[1];
    assign line.scl_rise = clk_en_i & scl_sync_q[1] & ~scl_d1_q;
    assign line.scl_fall = clk_en_i & ~scl_sync_q[1] & scl_d1_q;
    // data edges qualified by clock high on both samples
    assign line.start = clk_en_i & scl_sync_q[1] & scl_d1_q & sda_d1_q & ~sda_sync_q[1]; // RL1
    assign line.stop = clk_en_i & scl_sync_q[1] & scl_d1_q & ~sda_d1_q & sda_sync_q[1]; // RL2
    assign line.busy = busy_q;

    // busy tracking in every role, so other masters are seen too
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            busy_q <= 1'b0;
            stop_seen_q <= 1'b0;
            free_cnt_q <= 3'h0;
        end
        else if (clk_en_i)
        begin
            if (line.start) // RL4 RL21
            begin
                busy_q <= 1'b1;
                stop_seen_q <= 1'b0;
            end
            else if (line.stop)
            begin
                stop_seen_q <= 1'b1;
                free_cnt_q <= 3'h0;
            end
            else if (stop_seen_q)
            begin
                // a few clocks of grace before the bus is free
                if (free_cnt_q == BUSY_FREE_CYC - 3'h1) // RL4
                begin
                    busy_q <= 1'b0;
                    stop_seen_q <= 1'b0;
                end
                free_cnt_q <= free_cnt_q + 3'h1;
            end
        end
    end

    start_shape_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        line.start |-> (line.scl && !line.sda && $past(sda_sync_q[1]))) // RL1
        else $error("start seen without sda fall under high scl");
    stop_shape_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        line.stop |-> (line.scl && line.sda && !$past(sda_sync_q[1]))) // RL2
        else $error("stop seen without sda rise under high scl");
    busy_after_start_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        line.start |=> busy_q) // RL4
        else $error("bus not busy after start");
    free_after_stop_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (line.stop && clk_en_i) ##1 (!line.start && clk_en_i)[*4] |=> !busy_q) // RL4
        else $error("bus not free a few clocks after stop");
endmodule // twb_bus_monitor

/* File: twb_controller.sv */
`timescale 1ns/1ps
// Function
// RL1: start is sda falling while scl high
// RL2: stop is sda rising while scl high
// RL3: slave never makes start or stop
// RL4: busy from start, free shortly after stop
// RL5: address byte is seven bits plus direction
// RL6: first byte after start is the address
// RL7: bytes are eight bits, count unlimited
// RL8: most significant bit goes first
// RL9: receiver acknowledges on the ninth clock
// RL10: master clocks the acknowledge pulse
// RL11: starting master ends with the stop
// RL12: arbitration picks a single master; the code arbitrates during the address byte only
// RL13: master transmit holds scl low while flagged
// RL14: software loads next byte before clearing flag
// RL15: receive holds scl low while flagged
// RL16: software reads byte before clearing flag
// RL17: flag on byte, address match, lost arbitration
// RL18: acknowledge enable chooses ack or nack
// RL19: bus rate is source over prescale plus one
// RL20: losing master drops off the bus
// RL21: start and stop tracked in every role
module twb_controller
    import twb_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic start_req_i, // pulse: begin a master transfer
    input wire logic stop_req_i, // level: end after the current byte
    input wire logic hold_wr_i, // pulse: write the holding register
    input wire logic [7:0] hold_wdata_i,
    input wire logic flag_clr_i, // pulse: clear the event flag
    input wire logic ack_generate_enable_i,
    input wire logic prescale_source_select_i,
    input wire logic [3:0] bus_clock_prescale_i,
    input wire logic [6:0] own_addr_i,
    output logic [7:0] serial_data_holding_reg_o,
    output logic bus_event_flag_o,
    output logic busy_o,
    output logic master_o,
    output logic arb_lost_o,
    output logic ack_rx_o,
    output logic addr_match_o
);
    twb_line_if line ();

    twb_bus_monitor u_mon (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .line(line.mon)
    );

    twb_state_e state_q;
    logic [12:0] div_cnt_q; // half-period counter
    logic [12:0] half_lim; // half-period length in cycles
    logic tick; // end of a bus clock half period
    logic [7:0] shift_q; // byte shifter
    logic [3:0] bit_q; // bit position, 8 is the ack
    logic first_q; // address byte pending
    logic dir_rx_q; // this node receives the data bytes
    logic scl_oe_q;
    logic sda_oe_q;
    logic [7:0] hold_q;
    logic flag_q;
    logic flag_set; // hardware event this cycle
    logic cap_rx; // capture received byte into holding
    logic arb_q;
    logic ack_q;
    logic match_q;
    logic busy_q;
    logic master_q; // registered master role

    // bus clock: source divider times prescale plus one, split in halves
    assign half_lim = 13'({9'h0, bus_clock_prescale_i} + 13'h1)
        * (prescale_source_select_i ? HALF_SLOW : HALF_FAST); // RL19
    assign tick = clk_en_i && (div_cnt_q == half_lim - 13'h1);

    // half-period timer, held at zero while a slave stretches the high phase
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            div_cnt_q <= 13'h0;
        else if (clk_en_i)
        begin
            if (state_q == ST_IDLE || state_q == ST_HOLD || tick)
                div_cnt_q <= 13'h0;
            else if (state_q == ST_HIGH && !line.scl)
                div_cnt_q <= 13'h0; // wait for released scl
            else
                div_cnt_q <= div_cnt_q + 13'h1;
        end
    end

    // byte engine for master and slave roles
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bit_q <= 4'h0;
            first_q <= 1'b0;
            dir_rx_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            arb_q <= 1'b0;
            ack_q <= 1'b0;
            match_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            case (state_q)
                ST_IDLE:
                begin
                    scl_oe_q <= 1'b0;
                    sda_oe_q <= 1'b0;
                    if (start_req_i && !line.busy)
                    begin
                        sda_oe_q <= 1'b1; // RL1 start under released scl
                        shift_q <= hold_q; // RL6 RL5 address byte
                        first_q <= 1'b1;
                        dir_rx_q <= 1'b0;
                        arb_q <= 1'b0;
                        state_q <= ST_START;
                    end
                    else if (line.start)
                    begin
                        bit_q <= 4'h0; // RL21 follow another master
                        first_q <= 1'b1;
                        match_q <= 1'b0;
                        state_q <= ST_SLV;
                    end
                end
                ST_START:
                    if (tick)
                    begin
                        scl_oe_q <= 1'b1;
                        bit_q <= 4'h0;
                        state_q <= ST_LOW;
                    end
                ST_LOW:
                begin
                    // data moves two cycles after scl falls, so never beside an scl edge
                    if (div_cnt_q == 13'h1)
                        sda_oe_q <= (bit_q < BIT_ACK) ? !dir_rx_q && !shift_q[7] // RL8
                            : dir_rx_q && ack_generate_enable_i; // RL9 RL18
                    if (tick)
                    begin
                        scl_oe_q <= 1'b0; // RL10 master clocks every bit
                        state_q <= ST_HIGH;
                    end
                end
                ST_HIGH:
                    if (tick)
                    begin
                        scl_oe_q <= 1'b1;
                        if (bit_q < BIT_ACK)
                        begin
                            if (first_q && !sda_oe_q && !line.sda) // RL12 RL20
                            begin
                                arb_q <= 1'b1;
                                scl_oe_q <= 1'b0;
                                state_q <= ST_IDLE;
                            end
                            else
                            begin
                                shift_q <= {shift_q[6:0], line.sda}; // RL7
                                bit_q <= bit_q + 4'h1;
                                state_q <= ST_LOW;
                            end
                        end
                        else
                        begin
                            ack_q <= !line.sda;
                            if (first_q)
                                dir_rx_q <= shift_q[0]; // RL5 one means read
                            first_q <= 1'b0;
                            bit_q <= 4'h0;
                            state_q <= ST_HOLD;
                        end
                    end
                ST_HOLD:
                begin
                    // scl stays low until software clears the flag
                    sda_oe_q <= 1'b0;
                    if (!flag_q && !flag_set) // RL13 RL15
                    begin
                        if (stop_req_i) // RL11
                        begin
                            sda_oe_q <= 1'b1;
                            state_q <= ST_STOP_A;
                        end
                        else
                        begin
                            shift_q <= hold_q; // RL14 byte loaded beforehand
                            state_q <= ST_LOW;
                        end
                    end
                end
                ST_STOP_A:
                    if (tick)
                    begin
                        scl_oe_q <= 1'b0;
                        state_q <= ST_STOP_B;
                    end
                ST_STOP_B:
                    if (tick)
                    begin
                        sda_oe_q <= 1'b0; // RL2 sda rises under high scl
                        state_q <= ST_IDLE;
                    end
                ST_SLV:
                begin
                    if (line.stop)
                    begin
                        sda_oe_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                    else if (line.start)
                    begin
                        sda_oe_q <= 1'b0;
                        bit_q <= 4'h0;
                        first_q <= 1'b1;
                    end
                    else if (line.scl_rise)
                    begin
                        if (bit_q < BIT_ACK)
                        begin
                            shift_q <= {shift_q[6:0], line.sda};
                            bit_q <= bit_q + 4'h1;
                        end
                        else
                            ack_q <= !line.sda;
                    end
                    else if (line.scl_fall)
                    begin
                        // slave drives sda only after a falling scl edge
                        if (bit_q == BIT_ACK)
                        begin
                            if (!first_q || shift_q[7:1] == own_addr_i
                                || (shift_q[7:1] == GEN_CALL_ADDR && !shift_q[0]))
                            begin
                                if (first_q)
                                begin
                                    dir_rx_q <= !shift_q[0];
                                    match_q <= 1'b1;
                                end
                                first_q <= 1'b0;
                                sda_oe_q <= (first_q || dir_rx_q) && ack_generate_enable_i; // RL3 RL18
                                scl_oe_q <= 1'b1;
                                state_q <= ST_SLV_HOLD;
                            end
                            else
                                state_q <= ST_IDLE;
                        end
                        else if (bit_q == BIT_AFTER_ACK)
                        begin
                            bit_q <= 4'h0;
                            if (!dir_rx_q && ack_q)
                            begin
                                shift_q <= hold_q;
                                sda_oe_q <= !hold_q[7]; // RL8
                            end
                            else if (!dir_rx_q)
                            begin
                                sda_oe_q <= 1'b0; // nack ends slave transmit
                                state_q <= ST_IDLE;
                            end
                            else
                                sda_oe_q <= 1'b0;
                        end
                        else if (!dir_rx_q && !first_q) // RL3 silent while the address arrives
                            sda_oe_q <= !shift_q[7];
                    end
                end
                ST_SLV_HOLD:
                    if (!flag_q && !flag_set) // RL15 RL13
                    begin
                        scl_oe_q <= 1'b0;
                        bit_q <= BIT_AFTER_ACK;
                        state_q <= ST_SLV;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // events: byte done, address match, lost arbitration
    assign flag_set = clk_en_i && ((tick && state_q == ST_HIGH
        && (bit_q == BIT_ACK || (first_q && !sda_oe_q && !line.sda)))
        || (state_q == ST_SLV && line.scl_fall && bit_q == BIT_ACK && !line.stop && !line.start
        && (!first_q || shift_q[7:1] == own_addr_i
        || (shift_q[7:1] == GEN_CALL_ADDR && !shift_q[0])))); // RL17
    assign cap_rx = flag_set && !first_q && dir_rx_q;

    // event flag, hardware set beats a same-cycle software clear
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            flag_q <= 1'b0;
        else if (clk_en_i)
        begin
            if (flag_set) // RL17
                flag_q <= 1'b1;
            else if (flag_clr_i)
                flag_q <= 1'b0;
        end
    end

    // holding register, received byte wins over a cpu write
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            hold_q <= 8'h00;
        else if (clk_en_i)
        begin
            if (cap_rx) // RL16 read before clearing
                hold_q <= shift_q;
            else if (hold_wr_i)
                hold_q <= hold_wdata_i;
        end
    end

    // registered copies of busy and master role, so both outputs leave a flop
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            busy_q <= 1'b0;
            master_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            busy_q <= line.busy;
            master_q <= state_q inside {ST_START, ST_LOW, ST_HIGH, ST_HOLD, ST_STOP_A, ST_STOP_B};
        end
    end

    assign scl_o = 1'b0; // open drain, only ever pulls low
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_oe_q;
    assign sda_oe_o = sda_oe_q;
    assign serial_data_holding_reg_o = hold_q;
    assign bus_event_flag_o = flag_q;
    assign busy_o = busy_q;
    assign master_o = master_q;
    assign arb_lost_o = arb_q;
    assign ack_rx_o = ack_q;
    assign addr_match_o = match_q;

    hold_scl_low_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (state_q == ST_HOLD && flag_q) |=> scl_oe_q) // RL13 RL15
        else $error("scl released while event pending");
    flag_on_byte_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (state_q == ST_HIGH && tick && bit_q == BIT_ACK) |=> flag_q && state_q == ST_HOLD) // RL17
        else $error("no flag after master byte");
    arb_release_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        $rose(arb_q) |-> !sda_oe_q && !scl_oe_q && state_q == ST_IDLE) // RL20
        else $error("bus still driven after lost arbitration");
    msb_first_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (state_q == ST_LOW && tick && bit_q < BIT_ACK && !dir_rx_q)
        |=> sda_oe_q == !$past(shift_q[7])) // RL8
        else $error("bit driven is not the shifter msb");
    ack_drive_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (state_q == ST_LOW && tick && bit_q == BIT_ACK && dir_rx_q)
        |=> sda_oe_q == $past(ack_generate_enable_i)) // RL9 RL18
        else $error("ack level disagrees with enable");
    slave_no_cond_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ($past(state_q) == ST_SLV && $changed(sda_oe_q)) |-> !$past(line.scl) || $past(line.start)) // RL3
        else $error("slave moved sda while scl high");
endmodule // twb_controller

/* File: twb_line_if.sv */
`timescale 1ns/1ps
// synchronised bus lines and their events, monitor to byte engine
interface twb_line_if;
    logic scl; // synchronised clock line
    logic sda; // synchronised data line
    logic scl_rise; // one-cycle pulse
    logic scl_fall; // one-cycle pulse
    logic start; // one-cycle pulse on start condition
    logic stop; // one-cycle pulse on stop condition
    logic busy; // level, bus occupied
    modport mon (output scl, sda, scl_rise, scl_fall, start, stop, busy);
    modport eng (input scl, sda, scl_rise, scl_fall, start, stop, busy);
endinterface

/* File: twb_pkg.sv */
package twb_pkg;
    // prescaler source dividers of the system clock
    localparam int unsigned SRC_DIV_FAST = 16;
    localparam int unsigned SRC_DIV_SLOW = 512;
    // half of a bus clock period per prescale step, in system clock cycles
    localparam logic [12:0] HALF_FAST = 13'(SRC_DIV_FAST / 2);
    localparam logic [12:0] HALF_SLOW = 13'(SRC_DIV_SLOW / 2);
    // system clock cycles the bus stays busy after a stop
    localparam logic [2:0] BUSY_FREE_CYC = 3'h4;
    // bit counter landmarks within one byte
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_AFTER_ACK = 4'h9;
    // address reserved for the general call
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    // byte engine states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_START = 4'b0001,
        ST_LOW = 4'b0010,
        ST_HIGH = 4'b0011,
        ST_HOLD = 4'b0100,
        ST_STOP_A = 4'b0101,
        ST_STOP_B = 4'b0110,
        ST_SLV = 4'b0111,
        ST_SLV_HOLD = 4'b1000
    } twb_state_e;
endpackage

/* File: twb_slave_model.sv */
`timescale 1ns/1ps
// behavioural slave on the open-drain wires; may stretch scl mid-byte
module twb_slave_model #(
    parameter logic [6:0] ADDR = 7'h5a, // own address
    parameter logic [7:0] RD_BYTE = 8'ha6 // byte returned on reads
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [15:0] stretch_ns_i, // 0 answers promptly
    output logic scl_pull_o = 1'b0,
    output logic sda_pull_o = 1'b0,
    output logic [7:0] last_byte_o = 8'h00,
    output logic master_ack_o = 1'b0
);
    int cnt = 0; // clocks seen in this byte
    logic act = 1'b0; // addressed, or address still arriving
    logic rd = 1'b0; // read transfer
    logic first = 1'b0; // current byte is the address
    logic [7:0] sh = 8'h00; // incoming shift register
    // start seen in any role resets the framing
    always @(negedge sda_i)
        if (scl_i === 1'b1)
        begin
            act = 1'b1;
            first = 1'b1;
            rd = 1'b0;
            cnt = 0;
        end
    always @(posedge sda_i)
        if (scl_i === 1'b1)
            act = 1'b0;
    // sample on the rising clock
    always @(posedge scl_i)
        if (act)
        begin
            if (cnt < 8)
                sh = {sh[6:0], sda_i};
            else
                master_ack_o = ~sda_i;
            cnt++;
        end
    // drive only while scl is low, so no start or stop comes from here
    always @(negedge scl_i)
        if (act)
        begin
            if (cnt == 9)
            begin
                // a refused read byte frees sda so the master can stop
                if (rd && !first && master_ack_o !== 1'b1)
                    act = 1'b0;
                cnt = 0;
                first = 1'b0;
            end
            if (cnt == 8)
            begin
                last_byte_o = sh;
                if (first)
                    rd = sh[0];
                if (first)
                    act = (sh[7:1] == ADDR);
                sda_pull_o = act & (first | ~rd);
            end
            else
                sda_pull_o = act & rd & ~first & ~RD_BYTE[7 - cnt];
            if (cnt == 4 && stretch_ns_i != 0)
            begin
                scl_pull_o = 1'b1;
                #(stretch_ns_i) scl_pull_o = 1'b0;
            end
        end
endmodule // twb_slave_model

/* File: two_wire_bus_controller_tb.sv */
`timescale 1ns/1ps
module two_wire_bus_controller_tb
    import twb_pkg::*;
;
    localparam logic [6:0] SLV_ADDR = 7'h5a; // model address
    localparam logic [7:0] SLV_DATA = 8'ha6; // byte the model returns
    localparam logic [6:0] PEER_ADDR = 7'h33; // own address of the second controller
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic start_req = 1'b0, stop_req = 1'b0, hold_wr = 1'b0, flag_clr = 1'b0, ack_en = 1'b1, src_sel = 1'b0;
    logic [3:0] presc = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [15:0] stretch = 16'h0000;
    logic scl_oe, sda_oe, slv_scl, slv_pull, flag, busy, master, arb_lost, ack_rx, slv_ack;
    logic [7:0] hold_q, slv_byte, hold2;
    logic scl_oe2, sda_oe2, flag2, match2, flag_clr2;
    wire scl_bus = ~(scl_oe | slv_scl | scl_oe2); // pull-up on both wires
    wire sda_bus = ~(sda_oe | slv_pull | sda_oe2);
    int n_fail = 0, checked = 0, low_run = 0, last_low = 0;
    logic [7:0] rnd = 8'h61; // lfsr seed 97
    always #10 mclk = ~mclk;
    twb_controller twb_controller_i (.mclk_i(mclk), .resetn_i(resetn), .clk_en_i(1'b1), .scl_i(scl_bus), .scl_o(),
        .scl_oe_o(scl_oe), .sda_i(sda_bus), .sda_o(), .sda_oe_o(sda_oe), .start_req_i(start_req),
        .stop_req_i(stop_req), .hold_wr_i(hold_wr), .hold_wdata_i(wdata), .flag_clr_i(flag_clr),
        .ack_generate_enable_i(ack_en), .prescale_source_select_i(src_sel), .bus_clock_prescale_i(presc),
        .own_addr_i(7'h11), .serial_data_holding_reg_o(hold_q), .bus_event_flag_o(flag), .busy_o(busy),
        .master_o(master), .arb_lost_o(arb_lost), .ack_rx_o(ack_rx), .addr_match_o());
    twb_slave_model #(.ADDR(SLV_ADDR), .RD_BYTE(SLV_DATA)) twb_slave_model_i (.scl_i(scl_bus), .sda_i(sda_bus),
        .stretch_ns_i(stretch), .scl_pull_o(slv_scl), .sda_pull_o(slv_pull), .last_byte_o(slv_byte),
        .master_ack_o(slv_ack));
    // second controller as an addressed slave whose software clears each event at once
    always @(negedge mclk) flag_clr2 <= flag2;
    twb_controller twb_controller_peer_i (.mclk_i(mclk), .resetn_i(resetn), .clk_en_i(1'b1), .scl_i(scl_bus),
        .scl_o(), .scl_oe_o(scl_oe2), .sda_i(sda_bus), .sda_o(), .sda_oe_o(sda_oe2), .start_req_i(1'b0),
        .stop_req_i(1'b0), .hold_wr_i(1'b0), .hold_wdata_i(8'h00), .flag_clr_i(flag_clr2),
        .ack_generate_enable_i(1'b1), .prescale_source_select_i(1'b0), .bus_clock_prescale_i(4'h0),
        .own_addr_i(PEER_ADDR), .serial_data_holding_reg_o(hold2), .bus_event_flag_o(flag2), .busy_o(),
        .master_o(), .arb_lost_o(), .ack_rx_o(), .addr_match_o(match2));
    // length of the latest low half the controller drove
    always @(posedge mclk)
    begin
        low_run <= scl_oe ? low_run + 1 : 0;
        if (!scl_oe && low_run != 0)
            last_low <= low_run;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // bounded wait: k selects flag (0) or busy (1)
    task automatic wait_for(input int k, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && (k ? busy : flag) !== v; i++)
            @(negedge mclk);
        if ((k ? busy : flag) !== v)
        begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic clear_flag;
        flag_clr = 1'b1;
        @(negedge mclk) flag_clr = 1'b0;
        @(negedge mclk);
    endtask
    // one master transfer of the address and nbytes data bytes
    task automatic transfer(input logic [7:0] ab, input int nbytes, input logic src, input logic [3:0] p);
        int h, k;
        logic [7:0] d;
        src_sel = src;
        presc = p;
        h = int'(src ? HALF_SLOW : HALF_FAST) * (int'(p) + 1);
        wdata = ab;
        hold_wr = 1'b1;
        @(negedge mclk) hold_wr = 1'b0;
        start_req = 1'b1;
        @(negedge mclk) start_req = 1'b0;
        @(negedge mclk);
        check("start", 2'b10, {sda_oe, scl_oe});
        for (k = 0; k <= nbytes; k++)
        begin
            wait_for(0, 1'b1, 40 * h + 500);
            repeat (30) @(negedge mclk);
            check("scl_hold", 3'b111, {scl_oe, busy, master});
            if (k == 0)
                check("low_half", 1, last_low >= h && last_low <= h + 2);
            if (k == 0)
                check("addr_byte", ab, slv_byte);
            else if (ab[0])
                check("rx_byte", SLV_DATA, hold_q);
            else
                check("tx_byte", d, (ab[7:1] == PEER_ADDR) ? hold2 : slv_byte);
            if (k > 0 && ab[0])
                check("master_ack", ack_en, slv_ack);
            else
                check("ack_rx", ab[7:1] == SLV_ADDR || ab[7:1] == PEER_ADDR, ack_rx);
            if (!ab[0] && k < nbytes)
            begin
                rnd = lfsr(rnd);
                d = rnd;
                wdata = d;
                hold_wr = 1'b1;
                @(negedge mclk) hold_wr = 1'b0;
            end
            ack_en = (k < nbytes - 1); // last read byte refused
            stop_req = (k == nbytes);
            clear_flag();
        end
        wait_for(1, 1'b0, 8 * h + 200);
        check("end_state", {2'b00, ab[7:1] == PEER_ADDR}, {master, arb_lost, match2});
        stop_req = 1'b0;
        ack_en = 1'b1;
    endtask
    initial
    begin
        repeat (2) @(negedge mclk);
        check("reset", 4'h0, {scl_oe, sda_oe, flag, busy});
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
        rnd = lfsr(rnd);
        transfer({SLV_ADDR, 1'b0}, 3, 1'b0, {2'b00, rnd[1:0]});
        stretch = 16'd3000;
        transfer({SLV_ADDR, 1'b1}, 2, 1'b0, 4'h1);
        transfer({SLV_ADDR ^ 7'h01, 1'b0}, 0, 1'b0, 4'h0);
        stretch = 16'd0;
        transfer({PEER_ADDR, 1'b0}, 1, 1'b0, 4'h0);
        transfer({SLV_ADDR, 1'b0}, 1, 1'b1, 4'h0);
        conclude();
    end
endmodule // two_wire_bus_controller_tb
